// ===== pkg/fpm_pkg.sv
`default_nettype none
package fpm_pkg;
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int RECOVERY_MS = 100;
	localparam int BOOST_UV_MS = 110;
	localparam int RECOVERY_CYCLES = CLK_HZ / 1000 * RECOVERY_MS;
	localparam int BOOST_UV_CYCLES = CLK_HZ / 1000 * BOOST_UV_MS;
	localparam int TMR_W = 23;

	// register offsets
	localparam logic [7:0] ADDR_SUPPLY = 8'h00;
	localparam logic [7:0] ADDR_BOOST = 8'h04;
	localparam logic [7:0] ADDR_LED = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_CURRENT = 8'h10;

	// supply status fields
	localparam int S_IN_LOW = 0;
	localparam int S_IN_HIGH = 1;
	localparam int S_SUP_LOW = 2;
	localparam int S_IN_OCP = 3;
	localparam int S_PUMP = 4;
	localparam int S_PUMP_CAP = 5;
	localparam int S_CFG_CHK = 6;
	// boost status fields
	localparam int B_OVP_LOW = 0;
	localparam int B_OVP_HIGH = 1;
	localparam int B_OCP = 2;
	localparam int B_CHAN_RES = 3;
	localparam int B_DIM_RES = 4;
	localparam int B_FREQ_RES = 5;
	localparam int B_REF_SHORT = 6;
	localparam int B_THERMAL = 7;
	localparam logic [7:0] BOOST_IRQ_MASK = 8'hc6;
	// string status fields
	localparam int L_SUMMARY = 0;
	localparam int L_OPEN = 1;
	localparam int L_CHAN = 2;
	// control fields
	localparam int C_LED_INT_EN = 0;

	// reset values, defaults and the reference-short current shift
	localparam logic [11:0] CUR_RST = 12'hfff;
	localparam logic CTRL_LED_INT_RST = 1'h1;
	localparam int CUR_SHORT_SHIFT = 2;
	localparam logic [3:0] CHAN_MASK_DEF = 4'hf;
	localparam logic [1:0] DIM_PHASE_SHIFT = 2'h0;
	localparam logic [6:0] BUS_ADDR_DEF = 7'h3a;
	localparam logic [2:0] CONV_FREQ_400K = 3'h2;
	localparam logic [2:0] DIM_FREQ_305 = 3'h1;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_STARTUP,
		ST_ACTIVE,
		ST_STANDBY,
		ST_RECOVERY
	} fpm_state_t;

	typedef struct packed {
		logic in_low;
		logic in_high;
		logic sup_low;
		logic in_ocp;
		logic pump_low;
		logic ovp_low;
		logic ovp_high;
		logic bleed_high;
		logic conv_under;
		logic thermal;
		logic ref_short;
		logic cyc_lim;
		logic at_max;
		logic [3:0] margin_low;
	} fpm_cmp_t;
endpackage
`default_nettype wire

// ===== pkg/fpm_tmr_if.sv
`default_nettype none
interface fpm_tmr_if #(
	parameter int W = 23
);
	logic run;
	logic [W-1:0] limit;
	logic done;
	modport ctl(output run, output limit, input done);
	modport tmr(input run, input limit, output done);
endinterface
`default_nettype wire

// ===== hdl/fpm_timer.sv
`default_nettype none
module fpm_timer #(
	parameter int W = 23
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// control
	fpm_tmr_if.tmr t
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} fpm_tmr_st_t;

	fpm_tmr_st_t st;
	fpm_tmr_st_t next_st;
	logic last;

	// counts cycles of run, then holds done until run drops
	always_comb begin
		next_st = '0;
		last = (st.cnt == t.limit - W'(1));
		if (t.run) begin
			next_st.done = last;
			next_st.cnt = last ? st.cnt : st.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign t.done = st.done;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	chk_done_needs_run: assert property (t.done |-> $past(t.run))
		else $error("timer done without run");
	chk_done_at_limit: assert property ($rose(t.done) |-> $past(last))
		else $error("timer done before limit");
endmodule
`default_nettype wire

// ===== hdl/fpm_fault_mgr.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none
module fpm_fault_mgr #(
	parameter int RECOVERY_CYCLES = fpm_pkg::RECOVERY_CYCLES,
	parameter int BOOST_UV_CYCLES = fpm_pkg::BOOST_UV_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// analog comparators, asynchronous, high means tripped
	input wire logic input_low_sense_pin_i,
	input wire logic input_voltage_sense_pin_i,
	input wire logic logic_supply_low_i,
	input wire logic input_overcurrent_i,
	input wire logic pump_rail_pin_low_i,
	input wire logic converter_feedback_ovp_low_i,
	input wire logic converter_feedback_ovp_high_i,
	input wire logic output_bleed_pin_high_i,
	input wire logic converter_feedback_under_i,
	input wire logic thermal_trip_i,
	input wire logic current_reference_pin_short_i,
	input wire logic cycle_limit_i,
	input wire logic boost_at_max_i,
	input wire logic [3:0] sink_margin_low_i,
	// initialization results, same clock
	input wire logic init_valid_i,
	input wire logic pump_cap_bad_i,
	input wire logic config_load_bad_i,
	input wire logic chan_res_ok_i,
	input wire logic [3:0] chan_mask_i,
	input wire logic dim_res_ok_i,
	input wire logic [1:0] dim_mode_i,
	input wire logic [6:0] bus_addr_i,
	input wire logic converter_frequency_ok_i,
	input wire logic [2:0] converter_frequency_i,
	input wire logic dimming_frequency_ok_i,
	input wire logic [2:0] dimming_frequency_i,
	// power stage control
	output logic boost_en_o,
	output logic fet_en_o,
	output logic pump_en_o,
	output logic boost_switch_o,
	output logic [3:0] led_en_o,
	output logic start_o,
	output logic standby_o,
	output logic recovery_o,
	output logic int_o,
	output logic [11:0] string_current_code_o,
	// latched configuration
	output logic [3:0] chan_mask_o,
	output logic [1:0] dim_mode_o,
	output logic [6:0] bus_addr_o,
	output logic [2:0] converter_frequency_o,
	output logic [2:0] dimming_frequency_o
);
	localparam int TW = fpm_pkg::TMR_W;

	typedef struct packed {
		fpm_pkg::fpm_cmp_t s1;
		fpm_pkg::fpm_cmp_t s2;
		fpm_pkg::fpm_cmp_t s3;
		fpm_pkg::fpm_cmp_t f;
		fpm_pkg::fpm_state_t state;
		logic fresh;
		logic [6:0] sup;
		logic [7:0] bst;
		logic summary;
		logic open_det;
		logic [3:0] chan_flt;
		logic [3:0] dropped;
		logic led_int_en;
		logic [11:0] cur_prog;
		logic pump_off;
		logic [3:0] chan_mask;
		logic [1:0] dim_mode;
		logic [6:0] bus_addr;
		logic [2:0] conv_freq;
		logic [2:0] dim_freq;
		logic power;
		logic pump_en;
		logic boost_sw;
		logic [3:0] led_en;
		logic start;
		logic standby;
		logic recovery;
		logic irq;
		logic [11:0] cur_eff;
		logic [31:0] rdata;
	} fpm_st_t;

	fpm_st_t st;
	fpm_st_t next_st;
	fpm_pkg::fpm_cmp_t cmp;
	logic op;
	logic run;
	logic stby;
	logic rec;
	logic uv_exp;
	logic [3:0] hit;

	fpm_tmr_if #(.W(TW)) tmr_bus();

	fpm_timer #(.W(TW)) u_timer (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.t(tmr_bus.tmr)
	);

	// one timer: feedback-under window while active, retry delay in recovery
	assign tmr_bus.run = (st.state == fpm_pkg::ST_ACTIVE && st.f.conv_under) ||
		(st.state == fpm_pkg::ST_RECOVERY && !st.fresh);
	assign tmr_bus.limit = (st.state == fpm_pkg::ST_RECOVERY) ? TW'(RECOVERY_CYCLES) :
		TW'(BOOST_UV_CYCLES);

	function automatic logic irq_of(input logic [6:0] s, input logic [7:0] b,
		input logic sum, input logic en);
		irq_of = (|s) | (|(b & fpm_pkg::BOOST_IRQ_MASK)) | (sum & en);
	endfunction

	always_comb begin
		cmp = '{in_low: input_low_sense_pin_i, in_high: input_voltage_sense_pin_i,
			sup_low: logic_supply_low_i, in_ocp: input_overcurrent_i,
			pump_low: pump_rail_pin_low_i, ovp_low: converter_feedback_ovp_low_i,
			ovp_high: converter_feedback_ovp_high_i, bleed_high: output_bleed_pin_high_i,
			conv_under: converter_feedback_under_i, thermal: thermal_trip_i,
			ref_short: current_reference_pin_short_i, cyc_lim: cycle_limit_i,
			at_max: boost_at_max_i, margin_low: sink_margin_low_i};
		next_st = st;
		next_st.s1 = cmp;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// a level counts once the second and third stages agree
		next_st.f = fpm_pkg::fpm_cmp_t'((st.s2 & st.s3) | (st.f & (st.s2 | st.s3)));
		next_st.fresh = 1'b0;
		op = (st.state == fpm_pkg::ST_STARTUP) || (st.state == fpm_pkg::ST_ACTIVE);
		run = st.state == fpm_pkg::ST_ACTIVE;
		stby = st.f.in_low | st.f.in_high | st.f.sup_low | st.f.thermal;
		uv_exp = run && st.f.conv_under && tmr_bus.done;
		rec = st.f.in_ocp | (st.f.pump_low & ~st.pump_off) |
			(run & (st.f.ovp_high | st.f.bleed_high | uv_exp));
		hit = '0;

		// host writes; clears come first so a same-cycle set wins
		if (wr_i && addr_i == fpm_pkg::ADDR_SUPPLY) begin
			next_st.sup = st.sup & ~wdata_i[6:0];
		end
		if (wr_i && addr_i == fpm_pkg::ADDR_BOOST) begin
			next_st.bst = st.bst & ~wdata_i[7:0];
		end
		if (wr_i && addr_i == fpm_pkg::ADDR_LED && wdata_i[fpm_pkg::L_SUMMARY]) begin
			next_st.summary = 1'b0;
		end
		if (wr_i && addr_i == fpm_pkg::ADDR_CTRL) begin
			next_st.led_int_en = wdata_i[fpm_pkg::C_LED_INT_EN];
		end
		if (wr_i && addr_i == fpm_pkg::ADDR_CURRENT) begin
			next_st.cur_prog = wdata_i[11:0];
		end

		if (op) begin
			next_st.sup[fpm_pkg::S_IN_LOW] |= st.f.in_low;
			next_st.sup[fpm_pkg::S_IN_HIGH] |= st.f.in_high;
			next_st.sup[fpm_pkg::S_SUP_LOW] |= st.f.sup_low;
			next_st.sup[fpm_pkg::S_IN_OCP] |= st.f.in_ocp;
			next_st.sup[fpm_pkg::S_PUMP] |= st.f.pump_low & ~st.pump_off;
			next_st.bst[fpm_pkg::B_THERMAL] |= st.f.thermal;
			next_st.bst[fpm_pkg::B_REF_SHORT] |= st.f.ref_short;
		end
		if (run) begin
			next_st.bst[fpm_pkg::B_OVP_LOW] |= st.f.ovp_low;
			next_st.bst[fpm_pkg::B_OVP_HIGH] |= st.f.ovp_high | st.f.bleed_high;
			next_st.bst[fpm_pkg::B_OCP] |= uv_exp;
			if (st.f.at_max) begin
				hit = st.f.margin_low & st.chan_mask & ~st.dropped;
			end
		end
		next_st.dropped = st.dropped | hit;
		next_st.chan_flt = st.chan_flt | hit;
		if (|hit) begin
			next_st.open_det = 1'b1;
			next_st.summary = 1'b1;
		end

		unique case (st.state)
			fpm_pkg::ST_INIT: begin
				if (init_valid_i) begin
					// configuration is taken once and never rechecked
					next_st.chan_mask = chan_res_ok_i ? chan_mask_i :
						fpm_pkg::CHAN_MASK_DEF;
					next_st.dim_mode = dim_res_ok_i ? dim_mode_i :
						fpm_pkg::DIM_PHASE_SHIFT;
					next_st.bus_addr = dim_res_ok_i ? bus_addr_i :
						fpm_pkg::BUS_ADDR_DEF;
					next_st.conv_freq = converter_frequency_ok_i ? converter_frequency_i :
						fpm_pkg::CONV_FREQ_400K;
					next_st.dim_freq = dimming_frequency_ok_i ? dimming_frequency_i :
						fpm_pkg::DIM_FREQ_305;
					next_st.bst[fpm_pkg::B_CHAN_RES] |= ~chan_res_ok_i;
					next_st.bst[fpm_pkg::B_DIM_RES] |= ~dim_res_ok_i;
					next_st.bst[fpm_pkg::B_FREQ_RES] |= ~(converter_frequency_ok_i &
						dimming_frequency_ok_i);
					next_st.sup[fpm_pkg::S_CFG_CHK] |= config_load_bad_i;
					next_st.sup[fpm_pkg::S_PUMP_CAP] |= pump_cap_bad_i;
					next_st.sup[fpm_pkg::S_PUMP] |= pump_cap_bad_i;
					next_st.pump_off = pump_cap_bad_i;
					next_st.fresh = pump_cap_bad_i;
					next_st.state = pump_cap_bad_i ? fpm_pkg::ST_RECOVERY :
						fpm_pkg::ST_STARTUP;
				end
			end
			fpm_pkg::ST_STARTUP, fpm_pkg::ST_ACTIVE: begin
				if (stby) begin
					next_st.state = fpm_pkg::ST_STANDBY;
				end else if (rec) begin
					next_st.state = fpm_pkg::ST_RECOVERY;
					next_st.fresh = 1'b1;
				end else begin
					next_st.state = fpm_pkg::ST_ACTIVE;
				end
			end
			fpm_pkg::ST_STANDBY: begin
				if (!stby) begin
					next_st.state = fpm_pkg::ST_STARTUP;
				end
			end
			fpm_pkg::ST_RECOVERY: begin
				if (!st.fresh && tmr_bus.done) begin
					next_st.state = fpm_pkg::ST_STARTUP;
				end
			end
		endcase

		// outputs follow the next state so they change with it
		next_st.power = (next_st.state == fpm_pkg::ST_STARTUP) ||
			(next_st.state == fpm_pkg::ST_ACTIVE);
		next_st.start = (next_st.state == fpm_pkg::ST_STARTUP) &&
			(st.state != fpm_pkg::ST_STARTUP);
		next_st.standby = next_st.state == fpm_pkg::ST_STANDBY;
		next_st.recovery = next_st.state == fpm_pkg::ST_RECOVERY;
		next_st.pump_en = ~next_st.pump_off;
		next_st.led_en = (next_st.state == fpm_pkg::ST_ACTIVE) ?
			(next_st.chan_mask & ~next_st.dropped) : 4'h0;
		next_st.boost_sw = (next_st.state == fpm_pkg::ST_ACTIVE) &&
			!st.f.ovp_low && !st.f.cyc_lim;
		next_st.cur_eff = st.f.ref_short ?
			(st.cur_prog >> fpm_pkg::CUR_SHORT_SHIFT) : st.cur_prog;
		next_st.irq = irq_of(next_st.sup, next_st.bst, next_st.summary,
			next_st.led_int_en);

		next_st.rdata = 32'h0;
		if (rd_i) begin
			unique case (addr_i)
				fpm_pkg::ADDR_SUPPLY: next_st.rdata = {25'h0, st.sup};
				fpm_pkg::ADDR_BOOST: next_st.rdata = {24'h0, st.bst};
				fpm_pkg::ADDR_LED: next_st.rdata = {26'h0, st.chan_flt, st.open_det, st.summary};
				fpm_pkg::ADDR_CTRL: next_st.rdata = {31'h0, st.led_int_en};
				fpm_pkg::ADDR_CURRENT: next_st.rdata = {20'h0, st.cur_eff};
				default: next_st.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= '0;
			st.cur_prog <= fpm_pkg::CUR_RST;
			st.cur_eff <= fpm_pkg::CUR_RST;
			st.led_int_en <= fpm_pkg::CTRL_LED_INT_RST;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;
	assign boost_en_o = st.power;
	assign fet_en_o = st.power;
	assign pump_en_o = st.pump_en;
	assign boost_switch_o = st.boost_sw;
	assign led_en_o = st.led_en;
	assign start_o = st.start;
	assign standby_o = st.standby;
	assign recovery_o = st.recovery;
	assign int_o = st.irq;
	assign string_current_code_o = st.cur_eff;
	assign chan_mask_o = st.chan_mask;
	assign dim_mode_o = st.dim_mode;
	assign bus_addr_o = st.bus_addr;
	assign converter_frequency_o = st.conv_freq;
	assign dimming_frequency_o = st.dim_freq;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_in_op;
		op;
	endsequence

	sequence s_clean_active;
		run && !stby && !rec;
	endsequence

	chk_low_standby: assert property (s_in_op ##0 st.f.in_low |=>
		standby_o && !boost_en_o && st.sup[fpm_pkg::S_IN_LOW] && int_o)
		else $error("input undervoltage did not force standby");
	chk_standby_exit: assert property (st.state == fpm_pkg::ST_STANDBY && !stby |=>
		start_o && boost_en_o ##1 !start_o)
		else $error("standby not left after supply recovered");
	chk_high_standby: assert property (s_in_op ##0 st.f.in_high |=>
		standby_o && st.sup[fpm_pkg::S_IN_HIGH])
		else $error("input overvoltage did not force standby");
	chk_ocp_recovery: assert property (s_in_op ##0 (st.f.in_ocp && !stby) |=>
		recovery_o && !fet_en_o && st.sup[fpm_pkg::S_IN_OCP] ##1 recovery_o)
		else $error("input overcurrent did not enter recovery");
	chk_cycle_quiet: assert property (s_clean_active ##0 st.f.cyc_lim |=>
		!boost_switch_o && st.state == fpm_pkg::ST_ACTIVE)
		else $error("cycle limit misbehaved");
	chk_ovpl_stop: assert property (run && st.f.ovp_low |=>
		!boost_switch_o && st.bst[fpm_pkg::B_OVP_LOW])
		else $error("overvoltage low did not stop switching");
	chk_ref_quarter: assert property (st.f.ref_short |=>
		string_current_code_o == ($past(st.cur_prog) >> fpm_pkg::CUR_SHORT_SHIFT))
		else $error("reference short did not quarter current");
	chk_open_off: assert property (s_clean_active ##0 (st.f.at_max && |hit) |=>
		((led_en_o & $past(hit)) == 4'h0) && st.open_det && st.summary)
		else $error("open string not disabled");
	chk_detail_hold: assert property (st.open_det |=> st.open_det)
		else $error("open detail bit lost");
	chk_int_level: assert property ((st.sup != 7'h0) |-> int_o)
		else $error("interrupt dropped while supply flags set");
endmodule
`default_nettype wire

// ===== verification/fpm_cmp_model.sv
`default_nettype none
module fpm_cmp_model (
	// analog conditions requested by the bench
	input wire fpm_pkg::fpm_cmp_t fault_i,
	// comparator outputs, high means tripped
	output logic in_low_o,
	output logic in_high_o,
	output logic sup_low_o,
	output logic in_ocp_o,
	output logic pump_low_o,
	output logic ovp_low_o,
	output logic ovp_high_o,
	output logic bleed_high_o,
	output logic conv_under_o,
	output logic thermal_o,
	output logic ref_short_o,
	output logic cyc_lim_o,
	output logic at_max_o,
	output logic [3:0] margin_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// comparators settle off the clock grid, so the design must synchronise them
	assign #3 in_low_o = fault_i.in_low;
	assign #3 in_high_o = fault_i.in_high;
	assign #3 sup_low_o = fault_i.sup_low;
	assign #3 in_ocp_o = fault_i.in_ocp;
	assign #3 pump_low_o = fault_i.pump_low;
	assign #3 ovp_low_o = fault_i.ovp_low;
	assign #3 ovp_high_o = fault_i.ovp_high;
	assign #3 bleed_high_o = fault_i.bleed_high;
	assign #3 conv_under_o = fault_i.conv_under;
	assign #3 thermal_o = fault_i.thermal;
	assign #3 ref_short_o = fault_i.ref_short;
	assign #3 cyc_lim_o = fault_i.cyc_lim;
	assign #3 at_max_o = fault_i.at_max;
	assign #3 margin_low_o = fault_i.margin_low;
endmodule
`default_nettype wire

// ===== verification/fault_protection_manager_tb.sv
`default_nettype none
module fault_protection_manager_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REC = 50;
	localparam int UV = 60;
	logic clk_i = 0;
	logic resetn_i = 0;
	logic [7:0] addr_i = '0;
	logic [31:0] wdata_i = '0;
	logic wr_i = 0;
	logic rd_i = 0;
	logic [31:0] rdata_o;
	fpm_pkg::fpm_cmp_t cmp = '0;
	logic input_low_sense_pin_i, input_voltage_sense_pin_i, logic_supply_low_i;
	logic input_overcurrent_i, pump_rail_pin_low_i, converter_feedback_ovp_low_i;
	logic converter_feedback_ovp_high_i, output_bleed_pin_high_i, converter_feedback_under_i;
	logic thermal_trip_i, current_reference_pin_short_i, cycle_limit_i, boost_at_max_i;
	logic [3:0] sink_margin_low_i;
	logic init_valid_i = 0, pump_cap_bad_i = 0, config_load_bad_i = 0, chan_res_ok_i = 0;
	logic dim_res_ok_i = 0, converter_frequency_ok_i = 0, dimming_frequency_ok_i = 0;
	logic [3:0] chan_mask_i = 4'h3;
	logic [1:0] dim_mode_i = 2'h2;
	logic [6:0] bus_addr_i = 7'h11;
	logic [2:0] converter_frequency_i = 3'h5, dimming_frequency_i = 3'h6;
	logic boost_en_o, fet_en_o, pump_en_o, boost_switch_o, start_o, standby_o, recovery_o, int_o;
	logic [3:0] led_en_o, chan_mask_o;
	logic [11:0] string_current_code_o;
	logic [1:0] dim_mode_o;
	logic [6:0] bus_addr_o;
	logic [2:0] converter_frequency_o, dimming_frequency_o;
	logic [31:0] d;
	int miscompares = 0;
	int cmp_count = 0;

	fpm_cmp_model model (.fault_i(cmp), .in_low_o(input_low_sense_pin_i),
		.in_high_o(input_voltage_sense_pin_i), .sup_low_o(logic_supply_low_i),
		.in_ocp_o(input_overcurrent_i), .pump_low_o(pump_rail_pin_low_i),
		.ovp_low_o(converter_feedback_ovp_low_i), .ovp_high_o(converter_feedback_ovp_high_i),
		.bleed_high_o(output_bleed_pin_high_i), .conv_under_o(converter_feedback_under_i),
		.thermal_o(thermal_trip_i), .ref_short_o(current_reference_pin_short_i),
		.cyc_lim_o(cycle_limit_i), .at_max_o(boost_at_max_i), .margin_low_o(sink_margin_low_i));

	fpm_fault_mgr #(.RECOVERY_CYCLES(REC), .BOOST_UV_CYCLES(UV)) dut (.clk_i, .resetn_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .input_low_sense_pin_i,
		.input_voltage_sense_pin_i, .logic_supply_low_i, .input_overcurrent_i,
		.pump_rail_pin_low_i, .converter_feedback_ovp_low_i, .converter_feedback_ovp_high_i,
		.output_bleed_pin_high_i, .converter_feedback_under_i, .thermal_trip_i,
		.current_reference_pin_short_i, .cycle_limit_i, .boost_at_max_i, .sink_margin_low_i,
		.init_valid_i, .pump_cap_bad_i, .config_load_bad_i, .chan_res_ok_i, .chan_mask_i,
		.dim_res_ok_i, .dim_mode_i, .bus_addr_i, .converter_frequency_ok_i,
		.converter_frequency_i, .dimming_frequency_ok_i, .dimming_frequency_i, .boost_en_o,
		.fet_en_o, .pump_en_o, .boost_switch_o, .led_en_o, .start_o, .standby_o, .recovery_o,
		.int_o, .string_current_code_o, .chan_mask_o, .dim_mode_o, .bus_addr_o,
		.converter_frequency_o, .dimming_frequency_o);

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clk_i);
		rd_i <= 0;
		#1;
		d = rdata_o;
	endtask

	task automatic init(input logic cap_bad, input logic res_ok);
		@(posedge clk_i);
		init_valid_i <= 1;
		pump_cap_bad_i <= cap_bad;
		config_load_bad_i <= 1;
		chan_res_ok_i <= res_ok;
		dim_res_ok_i <= res_ok;
		converter_frequency_ok_i <= res_ok;
		dimming_frequency_ok_i <= res_ok;
		@(posedge clk_i);
		init_valid_i <= 0;
		#1;
	endtask

	// a fault of standby or recovery class: power off, flag, interrupt, then restart
	task automatic trip(input fpm_pkg::fpm_cmp_t f, input logic [7:0] a, input int b,
		input logic sb);
		@(posedge clk_i);
		cmp <= f;
		cyc(6);
		chk("standby", sb, standby_o);
		chk("recovery", !sb, recovery_o);
		chk("power", 6'h0, {boost_en_o, fet_en_o, led_en_o});
		rd(a);
		chk("flag", 1, d[b]);
		@(posedge clk_i);
		cmp <= '0;
		cyc(sb ? 8 : REC + 10);
		chk("restart", 3'h4, {boost_en_o, standby_o, recovery_o});
		chk("int held", 1, int_o);
		wr(a, 32'hff);
		cyc(2);
		chk("int cleared", 0, int_o);
	endtask

	initial begin
		fpm_pkg::fpm_cmp_t f;
		repeat (10) @(posedge clk_i);
		chk("reset current", 12'hfff, string_current_code_o);
		resetn_i <= 1;
		cyc(3);
		chk("idle", 3'h0, {boost_en_o, int_o, start_o});
		init(0, 0);
		chk("start", 1, start_o);
		chk("cfg", {4'hf, 2'h0, 7'h3a}, {chan_mask_o, dim_mode_o, bus_addr_o});
		chk("freq", {3'h2, 3'h1}, {converter_frequency_o, dimming_frequency_o});
		rd(fpm_pkg::ADDR_BOOST);
		chk("res flags", 3'h7, d[5:3]);
		rd(fpm_pkg::ADDR_SUPPLY);
		chk("crc flag", 1, d[6]);
		chk("crc int", 1, int_o);
		chk("crc runs", 1, boost_en_o);
		wr(fpm_pkg::ADDR_SUPPLY, 32'hff);
		cyc(2);
		chk("cfg no int", 0, int_o);
		wr(fpm_pkg::ADDR_BOOST, 32'hff);
		for (int k = 0; k < 8; k++) begin
			f = '0;
			case (k)
				0: f.in_low = 1;
				1: f.in_high = 1;
				2: f.sup_low = 1;
				3: f.thermal = 1;
				4: f.in_ocp = 1;
				5: f.pump_low = 1;
				6: f.ovp_high = 1;
				default: f.bleed_high = 1;
			endcase
			case (k)
				3: trip(f, fpm_pkg::ADDR_BOOST, fpm_pkg::B_THERMAL, 1);
				6, 7: trip(f, fpm_pkg::ADDR_BOOST, fpm_pkg::B_OVP_HIGH, 0);
				4: trip(f, fpm_pkg::ADDR_SUPPLY, fpm_pkg::S_IN_OCP, 0);
				5: trip(f, fpm_pkg::ADDR_SUPPLY, fpm_pkg::S_PUMP, 0);
				default: trip(f, fpm_pkg::ADDR_SUPPLY, k, 1);
			endcase
		end
		@(posedge clk_i);
		cmp.cyc_lim <= 1;
		cyc(6);
		chk("limit switch", 0, boost_switch_o);
		chk("limit quiet", 3'h0, {int_o, recovery_o, standby_o});
		rd(fpm_pkg::ADDR_SUPPLY);
		chk("limit flags", 0, d);
		@(posedge clk_i);
		f = '0;
		f.ovp_low = 1;
		cmp <= f;
		cyc(6);
		rd(fpm_pkg::ADDR_BOOST);
		chk("ovp low flag", 8'h01, d[7:0]);
		chk("ovp low", 4'h0, {boost_switch_o, int_o, recovery_o, standby_o});
		@(posedge clk_i);
		cmp <= '0;
		cyc(6);
		chk("switch back", 1, boost_switch_o);
		wr(fpm_pkg::ADDR_BOOST, 32'hff);
		@(posedge clk_i);
		cmp.conv_under <= 1;
		cyc(50);
		chk("under early", 0, recovery_o);
		cyc(20);
		chk("under trip", 2'h3, {recovery_o, int_o});
		rd(fpm_pkg::ADDR_BOOST);
		chk("under flag", 1, d[fpm_pkg::B_OCP]);
		@(posedge clk_i);
		cmp <= '0;
		cyc(REC + 10);
		chk("under retry", 1, boost_en_o);
		wr(fpm_pkg::ADDR_BOOST, 32'hff);
		wr(fpm_pkg::ADDR_CURRENT, 32'h800);
		@(posedge clk_i);
		cmp.ref_short <= 1;
		cyc(6);
		rd(fpm_pkg::ADDR_CURRENT);
		chk("quarter", 12'h200, d[11:0]);
		chk("quarter out", 12'h200, string_current_code_o);
		chk("ref int", 1, int_o);
		@(posedge clk_i);
		cmp <= '0;
		cyc(6);
		chk("restored", 12'h800, string_current_code_o);
		rd(fpm_pkg::ADDR_BOOST);
		chk("ref flag", 1, d[fpm_pkg::B_REF_SHORT]);
		wr(fpm_pkg::ADDR_BOOST, 32'hff);
		@(posedge clk_i);
		f = '0;
		f.at_max = 1;
		f.margin_low = 4'h2;
		cmp <= f;
		cyc(6);
		chk("open drop", 4'hd, led_en_o);
		rd(fpm_pkg::ADDR_LED);
		chk("open bits", 6'h0b, d[5:0]);
		chk("open int", 1, int_o);
		@(posedge clk_i);
		cmp <= '0;
		wr(fpm_pkg::ADDR_LED, 32'h1);
		cyc(2);
		chk("sum clear int", 0, int_o);
		rd(fpm_pkg::ADDR_LED);
		chk("detail hold", 6'h0a, d[5:0]);
		@(posedge clk_i);
		f = '0;
		f.at_max = 1;
		f.margin_low = 4'h4;
		cmp <= f;
		cyc(6);
		rd(fpm_pkg::ADDR_LED);
		chk("again", 6'h1b, d[5:0]);
		chk("again int", 2'h3, {int_o, led_en_o[0]});
		@(posedge clk_i);
		cmp <= '0;
		wr(fpm_pkg::ADDR_LED, 32'h1);
		wr(fpm_pkg::ADDR_CTRL, 32'h0);
		@(posedge clk_i);
		f = '0;
		f.at_max = 1;
		f.margin_low = 4'h8;
		cmp <= f;
		cyc(6);
		rd(fpm_pkg::ADDR_LED);
		chk("masked sum", 6'h3b, d[5:0]);
		chk("masked int", 0, int_o);
		@(posedge clk_i);
		cmp <= '0;
		resetn_i <= 0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1;
		cyc(2);
		init(1, 1);
		cyc(1);
		chk("cap", 3'h6, {recovery_o, int_o, pump_en_o});
		chk("cfg pins", {4'h3, 2'h2, 7'h11}, {chan_mask_o, dim_mode_o, bus_addr_o});
		chk("freq pins", {3'h5, 3'h6}, {converter_frequency_o, dimming_frequency_o});
		rd(fpm_pkg::ADDR_SUPPLY);
		chk("cap flags", 2'h3, d[5:4]);
		rd(fpm_pkg::ADDR_BOOST);
		chk("res ok flags", 3'h0, d[5:3]);
		@(posedge clk_i);
		f = '0;
		f.ref_short = 1;
		cmp <= f;
		cyc(6);
		chk("quarter default", 12'h3ff, string_current_code_o);
		finish_test();
	end

	initial begin
		#100us;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
